// *** src/uod_regs.vh ***
// register offsets, codes, limits and timing counts of the output driver
// assumes: included by bare name, definitions only
`ifndef UOD_REGS_VH
`define UOD_REGS_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define UOD_A_TYPE   4'h0
`define UOD_A_CFG    4'h1
`define UOD_A_XMIN   4'h2
`define UOD_A_XMAX   4'h3
`define UOD_A_YMIN   4'h4
`define UOD_A_YMAX   4'h5
`define UOD_A_FREQ   4'h6
`define UOD_A_DFREQ  4'h7
`define UOD_A_DAMP   4'h8
`define UOD_A_DELAY  4'h9
`define UOD_A_BLINK  4'hA
`define UOD_A_HOLD   4'hB
`define UOD_A_BOOST  4'hC
`define UOD_A_BTIME  4'hD
`define UOD_A_STAT   4'hE
// ----------------------------------------
// cfg field positions
// ----------------------------------------
`define UOD_F_RESP_HI 1
`define UOD_F_RESP_LO 0
`define UOD_F_SIDE    2
`define UOD_F_POL     3
// ----------------------------------------
// output types and digital responses
// ----------------------------------------
`define UOD_T_DIS   3'h0
`define UOD_T_CUR   3'h1
`define UOD_T_BOOST 3'h2
`define UOD_T_VOLT  3'h3
`define UOD_T_PWM   3'h4
`define UOD_T_DIG   3'h5
`define UOD_R_NORM  2'h0
`define UOD_R_INV   2'h1
`define UOD_R_LATCH 2'h2
`define UOD_R_BLINK 2'h3
// ----------------------------------------
// limits and reset values
// ----------------------------------------
`define UOD_YLIM_CUR  16'h07D0
`define UOD_YLIM_VOLT 16'h8CA0
`define UOD_YLIM_DUTY 16'h03E8
`define UOD_YLIM_DIG  16'h0001
`define UOD_XMAX_RST  16'h03E8
`define UOD_FULL      11'h3E8
// ----------------------------------------
// timing
// ----------------------------------------
`define UOD_CLK_HZ     200000000
`define UOD_CARRIER_HZ 16'h61A8
`define UOD_MS_TIME    1
`define UOD_MS_CYC     (`UOD_CLK_HZ / 1000 * `UOD_MS_TIME)
`define UOD_PERIOD_RST 28'h0001F40
`endif

// *** src/uod_driver.v ***
// one universal output: mapping, digital responses, pwm and current drive
// assumes: control, supply and load current come from logic on i_core_clk
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "uod_regs.vh"

// What this block does
// - output type codes 0 disabled to 5 plain digital on/off.
// - changing the type reloads config, output limits and delay to suit the new type.
// - current mode switches at 25 kHz with square dither at set frequency.
// - voltage mode duty equals target voltage over measured supply.
// - duty-cycle mode runs the set frequency, duty follows scaled control.
// - frequency writable only without current or boost outputs; these force 25 kHz.
// - plain digital ON drives the output fully on.
// - digital response codes 0 normal, 1 inverse, 2 latched, 3 blinking.
// - normal follows the command, inverse is its complement.
// - side code 0 low-side switching, 1 high-side switching.
// - normal response delays state changes by set milliseconds, zero means none.
// - polarity 0 delays off-to-on, 1 delays on-to-off; other edge immediate.
// - latched toggles on each off-to-on command, ignores on-to-off.
// - blinking alternates at blink rate while on, stays off while off.
// - blinking only for plain digital, not for boosted digital.
// - boosted digital regulates current, boost first then hold.
// - output is linear map y = m*x + a between configured limits.
// - output min and max ranges are limited by the selected type.
// - analog command turns off at or below min, on at or above max.
// - input axis needs min below max; output axis may be inverted.
module uod_driver #(
  parameter MS_CYC = `UOD_MS_CYC
) (
  input  wire        i_core_clk,
  input  wire        i_reset,
  input  wire        i_ce,
  input  wire [3:0]  i_addr,
  input  wire [15:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  input  wire [15:0] i_ctrl,
  input  wire [15:0] i_supply_mv,
  input  wire [15:0] i_iload_ma,
  input  wire        i_peer_lock,
  output reg  [15:0] o_rdata,
  output reg         o_hs_drive,
  output reg         o_ls_drive,
  output reg         o_state
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // type dependent ceiling of the output axis
  function [15:0] ylim;
    input [2:0] t;
    begin
      if (t == `UOD_T_CUR || t == `UOD_T_BOOST)
        ylim = `UOD_YLIM_CUR;
      else if (t == `UOD_T_VOLT)
        ylim = `UOD_YLIM_VOLT;
      else if (t == `UOD_T_PWM)
        ylim = `UOD_YLIM_DUTY;
      else
        ylim = `UOD_YLIM_DIG;
    end
  endfunction
  function [15:0] clip;
    input [15:0] v;
    input [15:0] lim;
    begin
      clip = (v > lim) ? lim : v;
    end
  endfunction
  // linear map, input clamped to the axis; ymin above ymax inverts
  function [15:0] lin_map;
    input [15:0] x;
    input [15:0] x0;
    input [15:0] x1;
    input [15:0] y0;
    input [15:0] y1;
    reg   [15:0] xc;
    reg signed [35:0] dy;
    reg signed [35:0] t;
    begin
      xc = (x < x0) ? x0 : ((x > x1) ? x1 : x);
      dy = $signed({20'h00000, y1}) - $signed({20'h00000, y0});
      t  = 36'sh0;
      if (x1 > x0)
        t = dy * $signed({20'h00000, xc - x0}) / $signed({20'h00000, x1 - x0});
      lin_map = y0 + t[15:0];
    end
  endfunction
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [2:0]  typ_q;
  reg [3:0]  cfg_q;
  reg [15:0] xmin_q, xmax_q, ymin_q, ymax_q, freq_q, dfreq_q, damp_q;
  reg [15:0] dly_q, blink_q, hold_q, boost_q, btime_q;
  reg        cmd_q, cmd_p_q, st_q, st_p_q, lat_q, bph_q, pwm_q, bact_q;
  reg [15:0] dms_q, blms_q, bms_q;
  reg [27:0] pcnt_q, period_q, dcnt_q;
  reg        dph_q;
  reg [10:0] rduty_q;
  reg [17:0] tick_q;
  reg [15:0] tgt;
  reg [10:0] duty;
  reg [31:0] vd;
  reg [38:0] oncyc;
  wire [1:0] resp   = cfg_q[`UOD_F_RESP_HI:`UOD_F_RESP_LO];
  wire       wr_typ = i_wr && i_addr == `UOD_A_TYPE && i_wdata[15:3] == 13'h0000 && i_wdata[2:0] != typ_q;
  wire       regul  = typ_q == `UOD_T_CUR || typ_q == `UOD_T_BOOST;
  // group lock: this output or the peer in current/boosted mode
  wire       locked = regul || i_peer_lock;
  wire       ms     = tick_q == MS_CYC - 1;
  wire       pend   = pcnt_q >= period_q - 28'h1;
  wire [15:0] y     = lin_map(i_ctrl, xmin_q, xmax_q, ymin_q, ymax_q);
  wire [15:0] ypwm  = clip(y, `UOD_YLIM_DUTY);
  wire [31:0] per_full = `UOD_CLK_HZ / {16'h0000, freq_q};
  // register writes; the type write reloads dependent settings
  always @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      typ_q   <= `UOD_T_DIS;
      cfg_q   <= 4'h0;
      xmin_q  <= 16'h0000;
      xmax_q  <= `UOD_XMAX_RST;
      ymin_q  <= 16'h0000;
      ymax_q  <= 16'h0000;
      freq_q  <= `UOD_CARRIER_HZ;
      dfreq_q <= 16'h0000;
      damp_q  <= 16'h0000;
      dly_q   <= 16'h0000;
      blink_q <= 16'h0000;
      hold_q  <= 16'h0000;
      boost_q <= 16'h0000;
      btime_q <= 16'h0000;
    end
    else if (i_ce)
    begin
      if (wr_typ && i_wdata[2:0] <= `UOD_T_DIG)
      begin
        typ_q  <= i_wdata[2:0];
        cfg_q  <= 4'h0;
        ymin_q <= 16'h0000;
        ymax_q <= ylim(i_wdata[2:0]);
        dly_q  <= 16'h0000;
      end
      else if (i_wr)
      begin
        if (i_addr == `UOD_A_CFG)
          cfg_q <= i_wdata[3:0];
        else if (i_addr == `UOD_A_XMIN && i_wdata < xmax_q)
          xmin_q <= i_wdata;
        else if (i_addr == `UOD_A_XMAX && i_wdata > xmin_q)
          xmax_q <= i_wdata;
        else if (i_addr == `UOD_A_YMIN)
          ymin_q <= clip(i_wdata, ylim(typ_q));
        else if (i_addr == `UOD_A_YMAX)
          ymax_q <= clip(i_wdata, ylim(typ_q));
        else if (i_addr == `UOD_A_DFREQ)
          dfreq_q <= i_wdata;
        else if (i_addr == `UOD_A_DAMP)
          damp_q <= i_wdata;
        else if (i_addr == `UOD_A_DELAY)
          dly_q <= i_wdata;
        else if (i_addr == `UOD_A_BLINK)
          blink_q <= i_wdata;
        else if (i_addr == `UOD_A_HOLD)
          hold_q <= clip(i_wdata, `UOD_YLIM_CUR);
        else if (i_addr == `UOD_A_BOOST)
          boost_q <= clip(i_wdata, `UOD_YLIM_CUR);
        else if (i_addr == `UOD_A_BTIME)
          btime_q <= i_wdata;
      end
      // forcing every cycle also catches the peer entering a locked mode
      if (locked)
        freq_q <= `UOD_CARRIER_HZ;
      else if (i_wr && i_addr == `UOD_A_FREQ && i_wdata != 16'h0000)
        freq_q <= i_wdata;
    end
  end
  // read data in the cycle after the strobe, zero when unmapped
  always @(posedge i_core_clk)
  begin
    if (i_reset)
      o_rdata <= 16'h0000;
    else if (i_ce)
    begin
      if (!i_rd)
        o_rdata <= 16'h0000;
      else if (i_addr == `UOD_A_TYPE)
        o_rdata <= {13'h0000, typ_q};
      else if (i_addr == `UOD_A_CFG)
        o_rdata <= {12'h000, cfg_q};
      else if (i_addr == `UOD_A_XMIN)
        o_rdata <= xmin_q;
      else if (i_addr == `UOD_A_XMAX)
        o_rdata <= xmax_q;
      else if (i_addr == `UOD_A_YMIN)
        o_rdata <= ymin_q;
      else if (i_addr == `UOD_A_YMAX)
        o_rdata <= ymax_q;
      else if (i_addr == `UOD_A_FREQ)
        o_rdata <= freq_q;
      else if (i_addr == `UOD_A_DFREQ)
        o_rdata <= dfreq_q;
      else if (i_addr == `UOD_A_DAMP)
        o_rdata <= damp_q;
      else if (i_addr == `UOD_A_DELAY)
        o_rdata <= dly_q;
      else if (i_addr == `UOD_A_BLINK)
        o_rdata <= blink_q;
      else if (i_addr == `UOD_A_HOLD)
        o_rdata <= hold_q;
      else if (i_addr == `UOD_A_BOOST)
        o_rdata <= boost_q;
      else if (i_addr == `UOD_A_BTIME)
        o_rdata <= btime_q;
      else if (i_addr == `UOD_A_STAT)
        o_rdata <= {1'b0, st_q, cmd_q, pwm_q, bact_q, duty};
      else
        o_rdata <= 16'h0000;
    end
  end
  // ----------------------------------------
  // digital command and responses
  // ----------------------------------------
  // hysteresis: unchanged between the axis limits
  always @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      cmd_q   <= 1'b0;
      cmd_p_q <= 1'b0;
      tick_q  <= 18'h00000;
    end
    else if (i_ce)
    begin
      if (i_ctrl <= xmin_q)
        cmd_q <= 1'b0;
      else if (i_ctrl >= xmax_q)
        cmd_q <= 1'b1;
      cmd_p_q <= cmd_q;
      tick_q  <= ms ? 18'h00000 : tick_q + 18'h00001;
    end
  end
  // state per response; reset clears the state and timers so the output starts off
  always @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      st_q   <= 1'b0;
      lat_q  <= 1'b0;
      bph_q  <= 1'b0;
      dms_q  <= 16'h0000;
      blms_q <= 16'h0000;
    end
    else if (i_ce)
    begin
      if (cmd_q && !cmd_p_q)
        lat_q <= ~lat_q;
      if (!cmd_q)
      begin
        bph_q  <= 1'b0;
        blms_q <= 16'h0000;
      end
      else if (ms)
      begin
        if (blms_q + 16'h0001 >= blink_q)
        begin
          blms_q <= 16'h0000;
          bph_q  <= ~bph_q;
        end
        else
          blms_q <= blms_q + 16'h0001;
      end
      if (typ_q != `UOD_T_BOOST && typ_q != `UOD_T_DIG)
        st_q <= 1'b0;
      else if (resp == `UOD_R_INV)
        st_q <= ~cmd_q;
      else if (resp == `UOD_R_LATCH)
        st_q <= lat_q;
      else if (resp == `UOD_R_BLINK && typ_q == `UOD_T_DIG)
        st_q <= cmd_q & ~bph_q;
      else if (cmd_q == st_q)
        dms_q <= 16'h0000;
      else if (dly_q == 16'h0000 || cmd_q == cfg_q[`UOD_F_POL])
        st_q <= cmd_q;
      else if (ms)
      begin
        if (dms_q + 16'h0001 >= dly_q)
        begin
          st_q  <= cmd_q;
          dms_q <= 16'h0000;
        end
        else
          dms_q <= dms_q + 16'h0001;
      end
    end
  end
  // ----------------------------------------
  // boost timer and dither
  // ----------------------------------------
  wire [31:0] dh_full = (dfreq_q == 16'h0000) ? 32'h00000001 : `UOD_CLK_HZ / {15'h0000, dfreq_q, 1'b0};
  wire [27:0] dhalf   = dh_full[27:0];
  always @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      st_p_q <= 1'b0;
      bact_q <= 1'b0;
      bms_q  <= 16'h0000;
      dcnt_q <= 28'h0000000;
      dph_q  <= 1'b0;
    end
    else if (i_ce)
    begin
      st_p_q <= st_q;
      if (!st_q)
        bact_q <= 1'b0;
      else if (!st_p_q)
      begin
        bact_q <= btime_q != 16'h0000;
        bms_q  <= btime_q;
      end
      else if (ms && bact_q)
      begin
        bms_q  <= bms_q - 16'h0001;
        bact_q <= bms_q > 16'h0001;
      end
      if (dcnt_q + 28'h0000001 >= dhalf)
      begin
        dcnt_q <= 28'h0000000;
        dph_q  <= ~dph_q;
      end
      else
        dcnt_q <= dcnt_q + 28'h0000001;
    end
  end
  // ----------------------------------------
  // duty and pwm
  // ----------------------------------------
  // duty in per mille for each type
  always @*
  begin
    tgt = 16'h0000;
    vd  = 32'h00000000;
    if (typ_q == `UOD_T_CUR)
      tgt = dph_q ? y + damp_q : ((y > damp_q) ? y - damp_q : 16'h0000);
    else if (typ_q == `UOD_T_BOOST && st_q)
      tgt = bact_q ? boost_q : hold_q;
    if (i_supply_mv != 16'h0000)
      vd = {16'h0000, y} * 32'd1000 / {16'h0000, i_supply_mv};
    if (regul)
      duty = rduty_q;
    else if (typ_q == `UOD_T_VOLT)
      duty = (vd > 32'd1000 || i_supply_mv == 16'h0000) ? `UOD_FULL : vd[10:0];
    else if (typ_q == `UOD_T_PWM)
      duty = ypwm[10:0];
    else if (typ_q == `UOD_T_DIG && st_q)
      duty = `UOD_FULL;
    else
      duty = 11'h000;
    oncyc = {11'h000, period_q} * {28'h0000000, duty} / 39'd1000;
  end
  // period counter, regulation loop and switch drive
  always @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      pcnt_q     <= 28'h0000000;
      period_q   <= `UOD_PERIOD_RST;
      rduty_q    <= 11'h000;
      pwm_q      <= 1'b0;
      o_state    <= 1'b0;
      o_hs_drive <= 1'b0;
      o_ls_drive <= 1'b0;
    end
    else if (i_ce)
    begin
      period_q <= per_full[27:0];
      pcnt_q   <= pend ? 28'h0000000 : pcnt_q + 28'h0000001;
      if (!regul || tgt == 16'h0000)
        rduty_q <= 11'h000;
      else if (pend && i_iload_ma < tgt && rduty_q < `UOD_FULL)
        rduty_q <= rduty_q + 11'h001;
      else if (pend && i_iload_ma > tgt && rduty_q != 11'h000)
        rduty_q <= rduty_q - 11'h001;
      pwm_q      <= {11'h000, pcnt_q} < oncyc;
      o_state    <= st_q;
      o_hs_drive <= pwm_q & cfg_q[`UOD_F_SIDE];
      o_ls_drive <= pwm_q & ~cfg_q[`UOD_F_SIDE];
    end
  end
endmodule // uod_driver
`default_nettype wire

// *** testbench/uod_chk_sv_hdr_unused_guard.svh ***
// shared bench limits for the output driver checks
// assumes: included by bare name, definitions only
`ifndef UOD_TB_SVH
`define UOD_TB_SVH
`define UOD_TB_MS 20
`endif

// *** testbench/uod_chk.sv ***
// checker: read port and drive relations of one output
// assumes: bound onto uod_driver, one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
module uod_chk #(
  parameter MS_CYC = 20
) (
  input wire        i_core_clk,
  input wire        i_reset,
  input wire        i_ce,
  input wire [3:0]  i_addr,
  input wire [15:0] i_wdata,
  input wire        i_wr,
  input wire        i_rd,
  input wire [15:0] i_ctrl,
  input wire [15:0] i_supply_mv,
  input wire [15:0] i_iload_ma,
  input wire        i_peer_lock,
  input wire [15:0] o_rdata,
  input wire        o_hs_drive,
  input wire        o_ls_drive,
  input wire        o_state
);
  // ----
  // properties
  // ----
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  // status read taken on this edge
  wire st_rd = i_rd && i_ce && (i_addr == 4'hE);
  // answer stands one cycle, else zero
  a_rd_one_cycle: assert property ($past(i_ce) && !$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data outside answer cycle");
  a_side_excl: assert property (!(o_hs_drive && o_ls_drive))
    else $error("both switches on");
  a_reset_off: assert property ($past(i_reset) |-> !o_state && !o_hs_drive && !o_ls_drive)
    else $error("output on after reset");
  a_type_legal: assert property ($past(i_rd && i_ce && i_addr == 4'h0) |-> o_rdata <= 16'h0005)
    else $error("illegal type read back");
  a_ylim_max: assert property ($past(i_rd && i_ce && (i_addr == 4'h4 || i_addr == 4'h5))
    |-> o_rdata <= 16'h8CA0)
    else $error("output limit beyond range");
  // frozen clock enable holds read data, state pin and high-side drive
  a_ce_freeze: assert property (!i_ce |=> $stable(o_rdata) && $stable(o_state) && $stable(o_hs_drive))
    else $error("state moved while frozen");
  a_stat_state: assert property ($past(st_rd) |-> o_rdata[14] == o_state)
    else $error("status state differs from pin state");
  a_stat_duty: assert property ($past(st_rd) |-> !o_rdata[15] && o_rdata[10:0] <= 11'h3E8)
    else $error("duty beyond full scale");
  a_drive_pwm: assert property ($past(st_rd) && (o_hs_drive || o_ls_drive) |-> o_rdata[12])
    else $error("switch on without pwm");
  c_stat_rd: cover property (st_rd);
  c_hs_on: cover property (o_hs_drive && o_state);
  c_ce_low: cover property (!i_ce ##1 i_ce);
endmodule // uod_chk
bind uod_driver uod_chk #(.MS_CYC(MS_CYC)) u_chk (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_ce(i_ce),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_ctrl(i_ctrl), .i_supply_mv(i_supply_mv),
  .i_iload_ma(i_iload_ma), .i_peer_lock(i_peer_lock), .o_rdata(o_rdata), .o_hs_drive(o_hs_drive),
  .o_ls_drive(o_ls_drive), .o_state(o_state));
`default_nettype wire

// *** testbench/uod_load.sv ***
// load model: coil current and supply seen by one output
// assumes: switch pins sampled on the core clock
`timescale 1ns/1ps
`default_nettype none
module uod_load #(
  parameter SUPPLY_MV = 16'h2EE0,
  parameter PEAK_MA   = 16'h09C4
) (
  input  wire         i_core_clk,
  input  wire         i_hs_drive,
  input  wire         i_ls_drive,
  output logic [15:0] o_supply_mv,
  output logic [15:0] o_iload_ma
);
  // coil current, starts at rest
  logic [15:0] coil_ma = 16'h0000;
  // first-order coil, slow so current loop sees lag
  always @(posedge i_core_clk)
  begin
    if (i_hs_drive || i_ls_drive)
      coil_ma <= coil_ma + ((PEAK_MA - coil_ma) >> 6);
    else
      coil_ma <= coil_ma - (coil_ma >> 6);
  end
  // stiff supply, no sag modelled
  assign o_supply_mv = SUPPLY_MV;
  assign o_iload_ma  = coil_ma;
endmodule // uod_load
`default_nettype wire

// *** testbench/universal_output_driver_bench.sv ***
// bench: register, digital, analog, delay and boost checks of one output
// assumes: uod_driver with a short ms tick, load model on its pins
`timescale 1ns/1ps
`default_nettype none
`include "uod_regs.vh"
`include "uod_chk_sv_hdr_unused_guard.svh"
module universal_output_driver_bench;
  logic        i_core_clk, i_reset, i_ce, i_wr, i_rd, i_peer_lock, rd_p, cmd, lat, pr;
  logic [3:0]  i_addr;
  logic [15:0] i_wdata, i_ctrl;
  logic [31:0] q[$];
  logic [31:0] nt;
  wire  [15:0] o_rdata, supply, iload;
  wire         o_hs_drive, o_ls_drive, o_state;
  integer      err_count, n_checks, cyc, seed, i, k, v, resp;
  uod_driver #(.MS_CYC(`UOD_TB_MS)) uut (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_ce(i_ce),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_ctrl(i_ctrl), .i_supply_mv(supply),
    .i_iload_ma(iload), .i_peer_lock(i_peer_lock), .o_rdata(o_rdata), .o_hs_drive(o_hs_drive),
    .o_ls_drive(o_ls_drive), .o_state(o_state));
  uod_load u_load (.i_core_clk(i_core_clk), .i_hs_drive(o_hs_drive), .i_ls_drive(o_ls_drive),
    .o_supply_mv(supply), .o_iload_ma(iload));
  // ----
  // tasks
  // ----
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
  begin
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
      err_count = err_count + 1;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task automatic tick(input integer n);
    repeat (n) @(posedge i_core_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
  begin
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  end
  endtask
  // read with a masked note for the watcher
  task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
  begin
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    q.push_back({m, e});
    @(posedge i_core_clk);
    i_rd <= 1'b0;
  end
  endtask
  // move the control value and track the bench's own command model
  task automatic ctl(input logic [15:0] c);
  begin
    i_ctrl <= c;
    if (c >= 16'h00C8 && !cmd)
      lat = ~lat;
    cmd = (c >= 16'h00C8) ? 1'b1 : (c <= 16'h0064) ? 1'b0 : cmd;
  end
  endtask
  task automatic stp(input logic [15:0] c);
  begin
    ctl(c);
    tick(3);
    rd(4'hE, 16'h4000, {1'b0, (resp == 0) ? cmd : (resp == 1) ? !cmd : lat, 14'h0000});
  end
  endtask
  task automatic dly(input logic [15:0] c, input logic early, input logic late);
  begin
    ctl(c);
    tick(10);
    rd(4'hE, 16'h4000, {1'b0, early, 14'h0000});
    tick(70);
    rd(4'hE, 16'h4000, {1'b0, late, 14'h0000});
  end
  endtask
  // count pin toggles over n cycles
  task automatic toggles(input integer n);
  begin
    k = 0;
    repeat (n)
    begin
      pr = o_state;
      @(posedge i_core_clk);
      #1 k = k + ((o_state !== pr) ? 1 : 0);
    end
  end
  endtask
  function automatic logic [15:0] ylim(input integer t);
    ylim = (t == 1 || t == 2) ? `UOD_YLIM_CUR : (t == 3) ? `UOD_YLIM_VOLT : (t == 4) ? `UOD_YLIM_DUTY : `UOD_YLIM_DIG;
  endfunction
  task automatic close_out;
  begin
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  // ----
  // clock, watcher and timeout
  // ----
  initial
  begin
    i_core_clk = 1'b0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end
  // pairs each read answer with the oldest note
  always @(posedge i_core_clk)
  begin
    if (rd_p)
    begin
      nt = q.pop_front();
      check(o_rdata & nt[31:16], nt[15:0]);
    end
    rd_p <= i_rd & i_ce;
    cyc = cyc + 1;
    if (cyc == 40000)
    begin
      err_count = err_count + 1;
      close_out();
    end
  end
  // ----
  // main sequence
  // ----
  initial
  begin
    {i_reset, i_ce, i_wr, i_rd, i_peer_lock, rd_p, cmd, lat} = 8'hC0;
    {i_addr, i_wdata, i_ctrl} = 36'h0;
    {err_count, n_checks, cyc, resp} = 0;
    seed = 44042;
    tick(5);
    i_reset <= 1'b0;
    rd(4'h0, 16'hFFFF, 16'h0000);
    rd(4'h3, 16'hFFFF, `UOD_XMAX_RST);
    rd(4'h6, 16'hFFFF, `UOD_CARRIER_HZ);
    rd(4'hF, 16'hFFFF, 16'h0000);
    rd(4'hE, 16'h4000, 16'h0000);
    $display("test reset done");
    for (i = 1; i < 7; i = i + 1)
    begin
      wr(4'h0, i[15:0]);
      rd(4'h0, 16'hFFFF, (i < 6) ? i[15:0] : 16'h0005);
      rd(4'h5, 16'hFFFF, ylim((i < 6) ? i : 5));
      wr(4'h4, 16'hFFFF);
      rd(4'h4, 16'hFFFF, ylim((i < 6) ? i : 5));
    end
    $display("test types done");
    wr(4'h0, 16'h0004);
    wr(4'h6, 16'hC350);
    rd(4'h6, 16'hFFFF, 16'hC350);
    i_peer_lock <= 1'b1;
    wr(4'h6, 16'h03E8);
    // a regulated peer drags the whole group to the carrier
    rd(4'h6, 16'hFFFF, `UOD_CARRIER_HZ);
    i_peer_lock <= 1'b0;
    wr(4'h0, 16'h0001);
    rd(4'h6, 16'hFFFF, `UOD_CARRIER_HZ);
    wr(4'h6, 16'h03E8);
    rd(4'h6, 16'hFFFF, `UOD_CARRIER_HZ);
    wr(4'h2, 16'h03E8);
    rd(4'h2, 16'hFFFF, 16'h0000);
    wr(4'h2, 16'h0064);
    wr(4'h3, 16'h00C8);
    rd(4'h3, 16'hFFFF, 16'h00C8);
    $display("test frequency and axis done");
    // duty mode: x 150 maps to 500 per mille, period 4000 cycles
    wr(4'h0, 16'h0004);
    wr(4'h6, 16'hC350);
    ctl(16'h0096);
    tick(10);
    rd(4'hE, 16'h07FF, 16'h01F4);
    k = 0;
    repeat (4000)
    begin
      @(posedge i_core_clk);
      k = k + o_ls_drive;
    end
    check({15'h0000, k > 1990 && k < 2010}, 16'h0001);
    wr(4'h0, 16'h0003);
    wr(4'h5, 16'h2EE0);
    tick(10);
    rd(4'hE, 16'h07FF, 16'h01F4);
    wr(4'h4, 16'h2EE0);
    wr(4'h5, 16'h0000);
    ctl(16'h007D);
    tick(10);
    rd(4'hE, 16'h07FF, 16'h02EE);
    $display("test analog done");
    wr(4'h0, 16'h0005);
    wr(4'h1, 16'h0004);
    stp(16'h0000);
    for (i = 0; i < 8; i = i + 1)
    begin
      v = {$random(seed)} % 300;
      stp(v[15:0]);
    end
    stp(16'h00C8);
    check({15'h0000, o_hs_drive}, 16'h0001);
    wr(4'h1, 16'h0000);
    tick(4);
    check({15'h0000, o_ls_drive}, 16'h0001);
    resp = 1;
    wr(4'h1, 16'h0001);
    stp(16'h0000);
    stp(16'h00C8);
    resp = 2;
    wr(4'h1, 16'h0002);
    stp(16'h0000);
    stp(16'h00C8);
    stp(16'h0000);
    stp(16'h00C8);
    resp = 0;
    wr(4'h1, 16'h0007);
    wr(4'hA, 16'h0002);
    stp(16'h0000);
    ctl(16'h00C8);
    toggles(400);
    check({15'h0000, k > 7 && k < 12}, 16'h0001);
    $display("test digital done");
    wr(4'h0, 16'h0002);
    wr(4'h1, 16'h0003);
    tick(10);
    toggles(400);
    check(k[15:0], 16'h0000);
    wr(4'hB, 16'h01F4);
    wr(4'hC, 16'h05DC);
    wr(4'hD, 16'h0002);
    stp(16'h0000);
    ctl(16'h00C8);
    tick(10);
    rd(4'hE, 16'h0800, 16'h0800);
    tick(80);
    rd(4'hE, 16'h0800, 16'h0000);
    ctl(16'h0000);
    tick(6);
    rd(4'hE, 16'h07FF, 16'h0000);
    $display("test boost done");
    wr(4'h0, 16'h0005);
    wr(4'h1, 16'h0004);
    wr(4'h9, 16'h0002);
    dly(16'h00C8, 1'b0, 1'b1);
    dly(16'h0000, 1'b0, 1'b0);
    wr(4'h1, 16'h000C);
    dly(16'h00C8, 1'b1, 1'b1);
    dly(16'h0000, 1'b1, 1'b0);
    i_ce <= 1'b0;
    tick(5);
    i_ce <= 1'b1;
    stp(16'h00C8);
    $display("test delay done");
    tick(4);
    // mid-run reset with the output on: state must come back off
    i_reset <= 1'b1;
    tick(2);
    i_reset <= 1'b0;
    cmd = 1'b0;
    lat = 1'b0;
    rd(4'hE, 16'hF800, 16'h0000);
    $display("test mid reset done");
    tick(4);
    close_out();
  end
endmodule // universal_output_driver_bench
`default_nettype wire
